// ### src/hrac_map.svh
// Functional notes
// - store request writes holding word into ram
// - store plus hold enters consecutive write
// - store alone writes once, self-clears
// - fetch request loads ram word into holding
// - fetch plus hold enters consecutive read
// - fetch alone reads once, self-clears
// - step direction only acts while hold set
// - consecutive step adds or subtracts four
// - control writes only from host, select low
// - cpu writes to control bits ignored
// - bit four reads zero
// - hold latches fetch/store value written with it
`ifndef HRAC_MAP_SVH
`define HRAC_MAP_SVH
// ----------------------------------------
// register indexes and fields
// ----------------------------------------
`define HRAC_IDX_CTRL   6'h04
`define HRAC_IDX_ADDR   6'h05
`define HRAC_IDX_DATA   6'h06
`define HRAC_BIT_HOLD   7
`define HRAC_BIT_STORE  5
`define HRAC_BIT_FETCH  3
`define HRAC_BIT_DIR    0
`define HRAC_CTRL_RST   8'h00
`define HRAC_ADDR_STEP  8'h01
`define HRAC_ADDR_W     8
`endif

// ### src/hrac_pkg.sv
package hrac_pkg;
    typedef struct packed {
        logic       hold;
        logic       store;
        logic       fetch;
        logic       dir;
    } hrac_ctrl_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD   = 2'b01,
        ST_WR   = 2'b10,
        ST_WAIT = 2'b11
    } hrac_state_t;
endpackage

// ### src/hrac_ram.sv
`timescale 1ns/1ps
`default_nettype none
module hrac_ram #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule
`default_nettype wire

// ### src/hrac_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hrac_map.svh"
module hrac_top (
    input  wire logic        MCLK_I,
    input  wire logic        RST_I,
    input  wire logic        REG_SEL_N_I,
    input  wire logic [5:0]  REG_INDEX_I,
    input  wire logic        HOST_WR_I,
    input  wire logic        HOST_RD_I,
    input  wire logic [31:0] HOST_WDATA_I,
    output logic      [31:0] HOST_RDATA_O,
    input  wire logic        CPU_WR_I,
    input  wire logic        CPU_SEL_DATA_I,
    input  wire logic [31:0] CPU_WDATA_I,
    output logic      [31:0] CPU_CTRL_O,
    output logic      [31:0] CPU_ADDR_O,
    output logic      [31:0] CPU_DATA_O,
    output logic             BUSY_O
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    hrac_pkg::hrac_ctrl_t  ctrl_ff;
    hrac_pkg::hrac_state_t st_ff;
    logic [7:0]  addr_ff;
    logic [31:0] data_ff;
    logic [31:0] ram_q;
    logic        ram_we;
    logic        host_ok;
    logic        wr_ctrl;
    logic        wr_addr;
    logic        wr_data;
    logic        rd_data;
    logic        lock_rd;
    logic        lock_wr;
    logic [7:0]  nxt_addr;

    assign host_ok = !REG_SEL_N_I;
    assign wr_ctrl = host_ok && HOST_WR_I && REG_INDEX_I == `HRAC_IDX_CTRL;
    assign wr_addr = host_ok && HOST_WR_I && REG_INDEX_I == `HRAC_IDX_ADDR;
    assign wr_data = host_ok && HOST_WR_I && REG_INDEX_I == `HRAC_IDX_DATA;
    assign rd_data = host_ok && HOST_RD_I && REG_INDEX_I == `HRAC_IDX_DATA;
    assign lock_rd = ctrl_ff.hold && ctrl_ff.fetch;
    assign lock_wr = ctrl_ff.hold && ctrl_ff.store;
    assign BUSY_O  = st_ff != hrac_pkg::ST_IDLE;
    assign ram_we  = st_ff == hrac_pkg::ST_WR;

    // step only in locked mode
    assign nxt_addr = ctrl_ff.dir ? addr_ff - `HRAC_ADDR_STEP
                                  : addr_ff + `HRAC_ADDR_STEP;

    hrac_ram #(.AW(`HRAC_ADDR_W), .DW(32)) u_ram (
        .clk_i   (MCLK_I),
        .we_i    (ram_we),
        .addr_i  (addr_ff),
        .wdata_i (data_ff),
        .rdata_o (ram_q)
    );

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_ff <= '0;
        end else if (wr_ctrl) begin
            ctrl_ff.hold  <= HOST_WDATA_I[`HRAC_BIT_HOLD];
            ctrl_ff.store <= HOST_WDATA_I[`HRAC_BIT_STORE];
            ctrl_ff.fetch <= HOST_WDATA_I[`HRAC_BIT_FETCH];
            ctrl_ff.dir   <= HOST_WDATA_I[`HRAC_BIT_DIR];
        end else if (!ctrl_ff.hold && st_ff == hrac_pkg::ST_WAIT) begin
            ctrl_ff.store <= 1'b0;
            ctrl_ff.fetch <= 1'b0;
        end
    end

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_ff <= hrac_pkg::ST_IDLE;
        end else begin
            unique case (st_ff)
                hrac_pkg::ST_IDLE: begin
                    if (wr_ctrl && HOST_WDATA_I[`HRAC_BIT_STORE]) begin
                        st_ff <= hrac_pkg::ST_WR;
                    end else if (wr_ctrl && HOST_WDATA_I[`HRAC_BIT_FETCH]) begin
                        st_ff <= hrac_pkg::ST_RD;
                    end else if (wr_data && lock_wr) begin
                        st_ff <= hrac_pkg::ST_WR;
                    end else if (rd_data && lock_rd) begin
                        st_ff <= hrac_pkg::ST_RD;
                    end
                end
                hrac_pkg::ST_RD:   st_ff <= hrac_pkg::ST_WAIT;
                hrac_pkg::ST_WR:   st_ff <= hrac_pkg::ST_WAIT;
                hrac_pkg::ST_WAIT: st_ff <= hrac_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // address and data holding
    // ----------------------------------------
    logic was_rd_ff;
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            was_rd_ff <= 1'b0;
        end else begin
            was_rd_ff <= st_ff == hrac_pkg::ST_RD;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            addr_ff <= '0;
        end else if (wr_addr) begin
            addr_ff <= HOST_WDATA_I[9:2];
        end else if (st_ff == hrac_pkg::ST_WAIT && ctrl_ff.hold) begin
            addr_ff <= nxt_addr;
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            data_ff <= '0;
        end else if (wr_data) begin
            data_ff <= HOST_WDATA_I;
        end else if (CPU_WR_I && CPU_SEL_DATA_I) begin
            data_ff <= CPU_WDATA_I;
        end else if (was_rd_ff) begin
            data_ff <= ram_q;
        end
    end

    // ----------------------------------------
    // read views
    // ----------------------------------------
    logic [31:0] ctrl_view;
    always_comb begin
        ctrl_view = '0;
        ctrl_view[`HRAC_BIT_HOLD]  = ctrl_ff.hold;
        ctrl_view[`HRAC_BIT_STORE] = ctrl_ff.store;
        ctrl_view[`HRAC_BIT_FETCH] = ctrl_ff.fetch;
        ctrl_view[`HRAC_BIT_DIR]   = ctrl_ff.dir;
    end

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            HOST_RDATA_O <= '0;
            CPU_CTRL_O   <= '0;
            CPU_ADDR_O   <= '0;
            CPU_DATA_O   <= '0;
        end else begin
            CPU_CTRL_O   <= ctrl_view;
            CPU_ADDR_O   <= {22'h000000, addr_ff, 2'h0};
            CPU_DATA_O   <= data_ff;
            unique case (REG_INDEX_I)
                `HRAC_IDX_CTRL: HOST_RDATA_O <= ctrl_view;
                `HRAC_IDX_ADDR: HOST_RDATA_O <= {22'h000000, addr_ff, 2'h0};
                `HRAC_IDX_DATA: HOST_RDATA_O <= data_ff;
                default:        HOST_RDATA_O <= '0;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_single_store_clr: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (st_ff == hrac_pkg::ST_WR && !ctrl_ff.hold && !wr_ctrl ##1 !wr_ctrl)
        |=> !ctrl_ff.store) else $error("store bit not cleared");
    a_fetch_loads: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (st_ff == hrac_pkg::ST_RD ##1 !wr_data && !(CPU_WR_I && CPU_SEL_DATA_I))
        |=> data_ff == $past(ram_q)) else $error("fetch did not load");
    a_store_writes: assert property (@(posedge MCLK_I) disable iff (RST_I)
        wr_ctrl && HOST_WDATA_I[`HRAC_BIT_STORE] && st_ff == hrac_pkg::ST_IDLE
        |=> ram_we) else $error("store missing");
    a_step_locked: assert property (@(posedge MCLK_I) disable iff (RST_I)
        st_ff == hrac_pkg::ST_WAIT && !ctrl_ff.hold && !wr_addr
        |=> addr_ff == $past(addr_ff)) else $error("stepped unlocked");
    a_step_inc: assert property (@(posedge MCLK_I) disable iff (RST_I)
        st_ff == hrac_pkg::ST_WAIT && ctrl_ff.hold && !ctrl_ff.dir && !wr_addr
        |=> addr_ff == $past(addr_ff) + 8'h01) else $error("bad increment");
    a_step_dec: assert property (@(posedge MCLK_I) disable iff (RST_I)
        st_ff == hrac_pkg::ST_WAIT && ctrl_ff.hold && ctrl_ff.dir && !wr_addr
        |=> addr_ff == $past(addr_ff) - 8'h01) else $error("bad decrement");
    a_lock_keeps: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ctrl_ff.hold && !wr_ctrl |=> $stable(ctrl_ff)) else $error("lock lost");
    a_cpu_ignored: assert property (@(posedge MCLK_I) disable iff (RST_I)
        !wr_ctrl && !ctrl_ff.store && !ctrl_ff.fetch |=> $stable(ctrl_ff))
        else $error("control changed without host");
    a_bit4_zero: assert property (@(posedge MCLK_I) disable iff (RST_I)
        CPU_CTRL_O[4] == 1'b0) else $error("reserved bit set");
    a_burst_write: assert property (@(posedge MCLK_I) disable iff (RST_I)
        wr_data && lock_wr && st_ff == hrac_pkg::ST_IDLE |=> ram_we ##2 !BUSY_O)
        else $error("burst write missing");
endmodule
`default_nettype wire

// ### verif/hrac_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "hrac_map.svh"
// ----------------------------------------
// host processor on the parallel port
// ----------------------------------------
module hrac_host (
    input  wire logic        clk_i,
    output logic             sel_n_o,
    output logic [5:0]       idx_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic [31:0]      wdata_o,
    input  wire logic [31:0] rdata_i,
    output logic [31:0]      rdata_o
);
    initial begin
        sel_n_o = 1'b1;
        idx_o   = 6'h3F;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 32'h0;
        rdata_o = 32'h0;
    end
    // one access held for one edge, then released lines toggle
    task automatic access(input logic [5:0] idx, input logic [31:0] d,
                          input logic wr, input logic sel_n);
        @(posedge clk_i);
        sel_n_o <= sel_n;
        idx_o   <= idx;
        wr_o    <= wr;
        rd_o    <= ~wr;
        wdata_o <= (idx == `HRAC_IDX_CTRL && d[3]) ? (d & 32'hFFFF_FFCF) : d;
        @(posedge clk_i);
        sel_n_o <= 1'b1;
        wr_o    <= 1'b0;
        rd_o    <= 1'b0;
        idx_o   <= ~idx_o;
        wdata_o <= ~wdata_o;
        // read data stands for one cycle after the taking edge
        @(posedge clk_i);
        rdata_o <= rdata_i;
        repeat (4) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ### verif/host_ram_access_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hrac_map.svh"
module host_ram_access_control_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sel_n;
    logic [5:0]  idx;
    logic        hwr;
    logic        hrd;
    logic [31:0] hwd;
    logic        cwr = 1'b0;
    logic        csel = 1'b0;
    logic [31:0] cwd = 32'h0;
    logic [31:0] ctrl_v;
    logic [31:0] addr_v;
    logic [31:0] data_v;
    logic        busy;
    logic [31:0] hrd_v;
    logic [31:0] host_q;
    int          mismatches = 0;
    int          n_checks = 0;
    always #50 clk = ~clk;
    hrac_host host (.clk_i(clk), .sel_n_o(sel_n), .idx_o(idx), .wr_o(hwr), .rd_o(hrd),
                    .wdata_o(hwd), .rdata_i(hrd_v), .rdata_o(host_q));
    hrac_top uut (.MCLK_I(clk), .RST_I(rst), .REG_SEL_N_I(sel_n), .REG_INDEX_I(idx),
                  .HOST_WR_I(hwr), .HOST_RD_I(hrd), .HOST_WDATA_I(hwd), .HOST_RDATA_O(hrd_v),
                  .CPU_WR_I(cwr), .CPU_SEL_DATA_I(csel), .CPU_WDATA_I(cwd),
                  .CPU_CTRL_O(ctrl_v), .CPU_ADDR_O(addr_v), .CPU_DATA_O(data_v),
                  .BUSY_O(busy));
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic hw(input logic [5:0] i, input logic [31:0] d);
        host.access(i, d, 1'b1, 1'b0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_single();
        chk("ctrl reset", ctrl_v, 32'h0);
        hw(`HRAC_IDX_ADDR, 32'h40);
        hw(`HRAC_IDX_DATA, 32'hA5C3_0F96);
        hw(`HRAC_IDX_CTRL, 32'h20);
        chk("store self clear", ctrl_v, 32'h0);
        hw(`HRAC_IDX_DATA, 32'h0);
        hw(`HRAC_IDX_CTRL, 32'h09);
        chk("fetched word", data_v, 32'hA5C3_0F96);
        chk("fetch self clear", ctrl_v, 32'h01);
        chk("no step unlocked", addr_v, 32'h40);
        $display("test single done");
    endtask
    task automatic t_refuse();
        host.access(`HRAC_IDX_CTRL, 32'h80, 1'b1, 1'b1);
        chk("select high ignored", ctrl_v, 32'h01);
        @(posedge clk);
        cwr  <= 1'b1;
        cwd  <= 32'hA0;
        @(posedge clk);
        csel <= 1'b1;
        @(posedge clk);
        cwr  <= 1'b0;
        csel <= 1'b0;
        repeat (4) @(posedge clk);
        chk("cpu ctrl ignored", ctrl_v, 32'h01);
        chk("cpu data write", data_v, 32'hA0);
        $display("test refuse done");
    endtask
    task automatic t_locked();
        hw(`HRAC_IDX_ADDR, 32'h80);
        hw(`HRAC_IDX_DATA, 32'hD000_0000);
        hw(`HRAC_IDX_CTRL, 32'hA0);
        for (int k = 0; k < 3; k++) begin
            chk("write step", addr_v, 32'h84 + 4 * k);
            chk("write lock held", ctrl_v, 32'hA0);
            hw(`HRAC_IDX_DATA, 32'hD000_0001 + k);
        end
        hw(`HRAC_IDX_CTRL, 32'h0);
        chk("write exit", ctrl_v, 32'h0);
        hw(`HRAC_IDX_ADDR, 32'h8C);
        hw(`HRAC_IDX_CTRL, 32'h89);
        for (int k = 0; k < 3; k++) begin
            chk("read word", data_v, 32'hD000_0003 - k);
            chk("read step", addr_v, 32'h88 - 4 * k);
            chk("read lock held", ctrl_v, 32'h89);
            host.access(`HRAC_IDX_DATA, 32'h0, 1'b0, 1'b0);
            chk("host read", host_q, 32'hD000_0003 - k);
        end
        hw(`HRAC_IDX_CTRL, 32'h0);
        chk("read exit", ctrl_v, 32'h0);
        chk("read last", data_v, 32'hD000_0000);
        chk("busy idle", {31'h0, busy}, 32'h0);
        $display("test locked done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_single();
        t_refuse();
        t_locked();
        close_out();
    end
    initial begin
        for (int c = 0; c < 20000; c++) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
